// [common/crpc_pkg.sv]
// Constants and types for the chip reset pin control block
package crpc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // Release hold, in internal clock cycles (plain default)
  localparam int unsigned HOLD_CYCLES     = 32;
  localparam int unsigned HOLD_CNT_W      = $clog2(HOLD_CYCLES + 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST =
    HOLD_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_RST = '0;

  // ---------------------------------------------------------------
  // Address width and pull-up disable bit positions
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_NARROW     = 16;
  localparam int unsigned ADDR_WIDE       = 20;
  localparam int unsigned PUD_RESET_BIT   = 0;
  localparam int unsigned PUD_BOOT_BIT    = 1;
  localparam int unsigned PUD_WIDE_BIT    = 2;
  localparam int unsigned PUD_W           = 3;
  localparam logic [PUD_W-1:0] PUD_RST    = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HELD,
    ST_COUNT,
    ST_RUN
  } crpc_state_t;

  // Mode latched at reset release
  typedef struct packed {
    logic boot_external;
    logic wide_address;
  } crpc_mode_t;

  localparam crpc_mode_t MODE_RST = '{boot_external: 1'b0,
                                      wide_address:  1'b0};

  // Pull-up enables for the reset pin and the strapped pins
  typedef struct packed {
    logic reset_pin;
    logic boot_pin;
    logic wide_pin;
  } crpc_pullup_t;

endpackage

// [verilog/crpc_reset_ctrl.sv]
// Reset pin combining, release counter, strap capture and status output
`timescale 1ns/1ps

// Contract
// - Reset pin low holds device in reset
// - Capture boot strap when reset released
// - Hold internal reset fixed cycles, release synchronously
// - Reset alone keeps debug logic running
// - Power-on reset asserts regardless of pin
// - Reset pull-up on while in reset; afterwards on unless disable bit set
// - Status output follows internal reset
// - External boot only when flash unsecured
// - Wide strap high enables 20 address lines
module crpc_reset_ctrl (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                por_n_i,
  input  wire logic                trst_n_i,
  input  wire logic                boot_source_strap_i,
  input  wire logic                wide_address_strap_i,
  input  wire logic                flash_secure_i,
  input  wire logic [2:0]          pullup_disable_reg_i,
  output logic                     core_rst_n_o,
  output logic                     debug_rst_n_o,
  output logic                     reset_state_output_o,
  output logic                     boot_external_o,
  output logic                     wide_address_o,
  output logic [4:0]               address_lines_o,
  output crpc_pkg::crpc_pullup_t   pullup_en_o
);

  // ---------------------------------------------------------------
  // Asynchronous reset combine
  // ---------------------------------------------------------------
  logic                             arst_n;
  logic                             sync1_reg;
  logic                             sync2_reg;
  logic                             strap_b1_reg;
  logic                             strap_b2_reg;
  logic                             strap_w1_reg;
  logic                             strap_w2_reg;
  logic [crpc_pkg::HOLD_CNT_W-1:0]  cnt_reg;
  logic [crpc_pkg::HOLD_CNT_W-1:0]  cnt_next;
  crpc_pkg::crpc_state_t            state_reg;
  crpc_pkg::crpc_state_t            state_next;
  crpc_pkg::crpc_mode_t             mode_reg;
  crpc_pkg::crpc_mode_t             mode_next;
  logic                             core_rst_n_reg;
  logic                             core_rst_n_next;
  logic                             capture;
  logic                             pud_reset_bit;

  // Either source pulls reset immediately
  assign arst_n = rstn_i & por_n_i;

  // ---------------------------------------------------------------
  // Release synchroniser and strap synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= 1'b1;
      sync2_reg <= sync1_reg;
    end
  end

  // Straps are pins: two flops before use, not reset by the pin
  always_ff @(posedge clk_i) begin
    strap_b1_reg <= boot_source_strap_i;
    strap_b2_reg <= strap_b1_reg;
    strap_w1_reg <= wide_address_strap_i;
    strap_w2_reg <= strap_w1_reg;
  end

  // ---------------------------------------------------------------
  // Release sequencer
  // ---------------------------------------------------------------
  assign capture = (state_reg == crpc_pkg::ST_HELD) && sync2_reg;

  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    core_rst_n_next = core_rst_n_reg;
    case (state_reg)
      crpc_pkg::ST_HELD: begin
        if (sync2_reg) begin
          state_next = crpc_pkg::ST_COUNT;
          cnt_next   = crpc_pkg::HOLD_CNT_RST;
        end
      end
      crpc_pkg::ST_COUNT: begin
        if (cnt_reg == crpc_pkg::HOLD_LAST) begin
          state_next      = crpc_pkg::ST_RUN;
          core_rst_n_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        core_rst_n_next = 1'b1;
      end
    endcase
  end

  // Strap capture on release; external boot gated by flash security
  always_comb begin
    mode_next = mode_reg;
    if (capture) begin
      mode_next.boot_external = strap_b2_reg & ~flash_secure_i;
      mode_next.wide_address  = strap_w2_reg;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= crpc_pkg::ST_HELD;
      cnt_reg        <= crpc_pkg::HOLD_CNT_RST;
      core_rst_n_reg <= 1'b0;
      mode_reg       <= crpc_pkg::MODE_RST;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      core_rst_n_reg <= core_rst_n_next;
      mode_reg       <= mode_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign core_rst_n_o         = core_rst_n_reg;
  assign reset_state_output_o = ~core_rst_n_reg;
  // Debug logic reset only by TRST or power-on
  assign debug_rst_n_o        = trst_n_i & por_n_i;
  assign boot_external_o      = mode_reg.boot_external;
  assign wide_address_o       = mode_reg.wide_address;
  assign address_lines_o      = mode_reg.wide_address ?
                                5'(crpc_pkg::ADDR_WIDE) :
                                5'(crpc_pkg::ADDR_NARROW);

  // Pull-ups on in reset; software disable honoured afterwards
  assign pud_reset_bit = pullup_disable_reg_i[crpc_pkg::PUD_RESET_BIT];
  assign pullup_en_o.reset_pin = ~core_rst_n_reg | ~pud_reset_bit;
  assign pullup_en_o.boot_pin  = ~core_rst_n_reg |
    ~pullup_disable_reg_i[crpc_pkg::PUD_BOOT_BIT];
  assign pullup_en_o.wide_pin  = ~core_rst_n_reg |
    ~pullup_disable_reg_i[crpc_pkg::PUD_WIDE_BIT];

endmodule

// [testbench/crpc_reset_ctrl_chk.sv]
// Port checker for the reset pin control block
`timescale 1ns/1ps
module crpc_reset_ctrl_chk (
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire logic                  por_n_i,
  input wire logic                  trst_n_i,
  input wire logic                  boot_source_strap_i,
  input wire logic                  flash_secure_i,
  input wire logic [2:0]            pullup_disable_reg_i,
  input wire logic                  core_rst_n_o,
  input wire logic                  debug_rst_n_o,
  input wire logic                  reset_state_output_o,
  input wire logic                  boot_external_o,
  input wire logic                  wide_address_o,
  input wire logic [4:0]            address_lines_o,
  input wire crpc_pkg::crpc_pullup_t pullup_en_o
);
  wire logic  arst_n = rstn_i & por_n_i;
  logic [7:0] cnt_reg;
  // Cycles since release, saturating
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n);
  a_release_at_count: assert property ($rose(core_rst_n_o) |->
    cnt_reg == 8'h23) else $error("core reset released at wrong cycle");
  a_core_held_early: assert property (cnt_reg < 8'h23 |->
    !core_rst_n_o) else $error("core reset released early");
  a_status_mirror: assert property (
    reset_state_output_o == !core_rst_n_o) else $error("status pin wrong");
  a_debug_follows_trst: assert property (
    debug_rst_n_o == trst_n_i) else $error("debug reset wrong");
  a_boot_capture: assert property (cnt_reg == 8'h03 |->
    boot_external_o == ($past(boot_source_strap_i, 3) &&
    !$past(flash_secure_i))) else $error("boot mode captured wrong");
  a_modes_hold: assert property (core_rst_n_o |->
    $stable({boot_external_o, wide_address_o})) else $error("mode moved");
  a_wide_lines: assert property (
    address_lines_o == (wide_address_o ? 5'h14 : 5'h10))
    else $error("address line count wrong");
  a_pullup_forced: assert property (!core_rst_n_o |->
    pullup_en_o == 3'h7) else $error("pull-ups off in reset");
  a_pullup_follow: assert property (
    core_rst_n_o && $stable(pullup_disable_reg_i) |-> pullup_en_o ==
    ~{pullup_disable_reg_i[0], pullup_disable_reg_i[1],
    pullup_disable_reg_i[2]}) else $error("pull-ups ignore disable");
  c_release: cover property ($rose(core_rst_n_o));
  c_boot_ext: cover property (core_rst_n_o && boot_external_o);
  c_wide: cover property (core_rst_n_o && wide_address_o);
endmodule
bind crpc_reset_ctrl crpc_reset_ctrl_chk u_chk (.clk_i, .rstn_i, .por_n_i,
  .trst_n_i, .boot_source_strap_i, .flash_secure_i, .pullup_disable_reg_i,
  .core_rst_n_o, .debug_rst_n_o, .reset_state_output_o, .boot_external_o,
  .wide_address_o, .address_lines_o, .pullup_en_o);

// [testbench/crpc_reset_src.sv]
// Board reset source for the reset, test reset and strap pins
`timescale 1ns/1ps
module crpc_reset_src (
  input  wire logic clk_i,
  output logic      rstn_o = 1'b0,
  output logic      trst_n_o = 1'b0,
  output logic      boot_o = 1'b0,
  output logic      wide_o = 1'b0
);
  // Full reset pulls test reset with it
  task automatic hold(input logic full, input logic b, input logic w);
    @(posedge clk_i);
    rstn_o <= 1'b0;
    trst_n_o <= !full;
    boot_o <= b;
    wide_o <= w;
  endtask
  task automatic free();
    @(posedge clk_i);
    rstn_o <= 1'b1;
    trst_n_o <= 1'b1;
  endtask
endmodule

// [testbench/crpc_reset_ctrl_bench.sv]
// Self-checking bench for the reset pin control block
`timescale 1ns/1ps
module crpc_reset_ctrl_bench;
  logic clk_i = 1'b0, por_n_i = 1'b0, flash_secure_i = 1'b0;
  logic [2:0] pud = 3'h0;
  logic rstn_i, trst_n_i, bs, ws, core_n, dbg_n, stat, bx, wx;
  logic [4:0] lines;
  crpc_pkg::crpc_pullup_t pu;
  int error_cnt = 0, total_checks = 0, cyc = 0, n, k;
  crpc_reset_src src (.clk_i, .rstn_o(rstn_i), .trst_n_o(trst_n_i),
    .boot_o(bs), .wide_o(ws));
  crpc_reset_ctrl dut (.clk_i, .rstn_i, .por_n_i, .trst_n_i,
    .boot_source_strap_i(bs), .wide_address_strap_i(ws), .flash_secure_i,
    .pullup_disable_reg_i(pud), .core_rst_n_o(core_n),
    .debug_rst_n_o(dbg_n), .reset_state_output_o(stat),
    .boot_external_o(bx), .wide_address_o(wx), .address_lines_o(lines),
    .pullup_en_o(pu));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] exp_lines(input logic w);
    return w ? 8'h14 : 8'h10;
  endfunction
  task automatic check(input string nm, input logic [7:0] e, got);
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, got);
    end
  endtask
  task automatic run(input logic f, b, w, s, p);
    @(posedge clk_i) flash_secure_i <= s;
    if (p) @(posedge clk_i) por_n_i <= 1'b0;
    else src.hold(f, b, w);
    repeat (3) @(posedge clk_i);
    #1 check("core", 8'h00, {7'h0, core_n});
    check("stat", 8'h01, {7'h0, stat});
    check("pull", 8'h07, {5'h0, pu});
    check("dbg", {7'h0, !(f | p)}, {7'h0, dbg_n});
    if (p) @(posedge clk_i) por_n_i <= 1'b1;
    else src.free();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      #1;
    end while (!core_n && n < 100);
    check("hold", 8'h23, n[7:0]);
    check("boot", {7'h0, bs & !s}, {7'h0, bx});
    check("lines", exp_lines(ws), {3'h0, lines});
    check("wide", {7'h0, ws}, {7'h0, wx});
    check("stat_run", 8'h00, {7'h0, stat});
    @(posedge clk_i) pud <= 3'($urandom);
    repeat (2) @(posedge clk_i);
    #1 check("pull", {5'h0, ~{pud[0], pud[1], pud[2]}}, {5'h0, pu});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(72171));
    repeat (16) @(posedge clk_i);
    por_n_i <= 1'b1;
    src.free();
    for (int i = 0; i < 20; i++) begin
      k = (i < 16) ? i : (i == 16) ? 16 : $urandom;
      if (i == 9) begin
        src.hold(1'b0, 1'b1, 1'b1);
        src.free();
        repeat (10) @(posedge clk_i);
      end
      run(k[0], k[1], k[2], k[3], k[4]);
    end
    tally_and_finish();
  end
endmodule
